// File: rtl/srg_pkg.sv
package srg_pkg;
    // Wishbone register word offsets (byte addresses)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_BUFFER = 4'h4;
    localparam logic [3:0] ADDR_RELOAD = 4'h8;
    localparam logic [3:0] ADDR_RATE_CFG = 4'hc;

    // serial_control and rate config bit positions
    localparam int CTL_RX_DONE = 0;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_NINTH = 2;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_EN = 4;
    localparam int CTL_ADDR_ONLY = 5;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MODE_HI = 7;
    localparam int CFG_EXT_SEL = 0;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;

    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
    localparam logic [1:0] MODE_UART9_VAR = 2'h3;

    // Divide factors, tick sample points and bit counts
    localparam logic [3:0] DIV_OSC12_MAX = 4'hb;
    localparam logic [5:0] DIV_OSC64_MAX = 6'h3f;
    localparam logic [3:0] DIV_OSC4_MAX = 4'h3;
    localparam logic [1:0] DIV_TICK32_MAX = 2'h1;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_S7 = 4'h6;
    localparam logic [3:0] TICK_S8 = 4'h7;
    localparam logic [3:0] TICK_S9 = 4'h8;
    localparam logic [3:0] BITS_MODE1 = 4'h9;
    localparam logic [3:0] BITS_MODE23 = 4'ha;
    localparam logic [3:0] BITS_SHIFT = 4'h8;
endpackage

// File: rtl/srg_rate_gen.sv
`timescale 1ns/1ns
// Produces one pulse per sixteenth of a bit time (or per bit in shift mode)
module srg_rate_gen (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [1:0] mode_i,
    input wire logic ext_sel_i,
    input wire logic ext_count_input_i,
    input wire logic [7:0] rate_reload_value_i,
    input wire logic restart_i,
    output logic bit_pulse_o,
    output logic tick_o
);
    logic [3:0] div12;
    logic [5:0] div64;
    logic [7:0] rate_cnt;
    logic [1:0] div2;
    logic ext_prev;
    logic osc12;
    logic cnt_step;
    logic cnt_ovf;
    logic shift_mode;
    logic fixed64;

    assign shift_mode = (mode_i == srg_pkg::MODE_SHIFT);
    assign fixed64 = (mode_i == srg_pkg::MODE_UART9_FIXED);
    assign osc12 = (div12 == srg_pkg::DIV_OSC12_MAX);
    assign cnt_step = ext_sel_i ? (ext_prev & ~ext_count_input_i) : osc12;
    assign cnt_ovf = cnt_step && (rate_cnt == 8'hff);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div12 <= 4'h0;
            ext_prev <= 1'b0;
        end else if (ce_i) begin
            div12 <= osc12 ? 4'h0 : div12 + 4'h1;
            ext_prev <= ext_count_input_i;
        end
    end

    // Reloading counter; restart keeps a fresh bit grid after receive enable
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rate_cnt <= 8'h00;
            div64 <= 6'h00;
            div2 <= 2'h0;
        end else if (ce_i) begin
            if (restart_i) begin
                rate_cnt <= rate_reload_value_i;
                div64 <= 6'h00;
                div2 <= 2'h0;
            end else begin
                if (cnt_ovf) begin
                    rate_cnt <= rate_reload_value_i;
                end else if (cnt_step) begin
                    rate_cnt <= rate_cnt + 8'h01;
                end
                div64 <= (div64 == srg_pkg::DIV_OSC64_MAX) ? 6'h00 : div64 + 6'h01;
                if (cnt_ovf) begin
                    div2 <= (div2 == srg_pkg::DIV_TICK32_MAX) ? 2'h0 : div2 + 2'h1;
                end
            end
        end
    end

    // 32 = 16 ticks x 2; fixed 64 = 16 ticks x 4 clocks
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
            bit_pulse_o <= 1'b0;
        end else if (ce_i) begin
            bit_pulse_o <= shift_mode && osc12 && !restart_i;
            if (fixed64) begin
                tick_o <= (div64[1:0] == srg_pkg::DIV_OSC4_MAX[1:0]) && !restart_i;
            end else begin
                tick_o <= cnt_ovf && (div2 == srg_pkg::DIV_TICK32_MAX) && !restart_i;
            end
        end
    end
endmodule

// File: rtl/srg_serial_rx.sv
`timescale 1ns/1ns
module srg_serial_rx (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_line_i,
    input wire logic ext_count_input_i,
    input wire logic tx_done_set_i,
    output logic serial_irq_o,
    output logic shift_clk_o
);
    typedef enum logic [2:0] {
        SRG_IDLE = 3'b001,
        SRG_START = 3'b010,
        SRG_DATA = 3'b100
    } srg_state_t;

    srg_state_t state;
    logic [7:0] serial_control;
    logic [7:0] serial_buffer;
    logic [7:0] rate_reload_value;
    logic ext_sel;
    logic [8:0] shifter;
    logic [3:0] tick_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] votes;
    logic line_prev;
    logic rx_en_prev;
    logic tick;
    logic bit_pulse;
    logic restart;
    logic majority;
    logic sample_now;
    logic last_bit;
    logic deliver;
    logic wr;
    logic rd_ack;
    logic [1:0] mode;
    logic [31:0] next_rdata;

    assign mode = serial_control[srg_pkg::CTL_MODE_HI:srg_pkg::CTL_MODE_LO];
    assign restart = serial_control[srg_pkg::CTL_RX_EN] && !rx_en_prev;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Third vote is the live line, so all three samples belong to the bit being judged
    assign majority = (votes[0] & votes[1]) | (votes[0] & rx_line_i) |
                      (votes[1] & rx_line_i);
    assign sample_now = tick && (tick_cnt == srg_pkg::TICK_S9);
    // Count includes the bit now sampled, so the ninth or tenth bit is the last data bit
    assign last_bit = (mode == srg_pkg::MODE_UART8) ?
                      (bit_cnt + 4'h1 == srg_pkg::BITS_MODE1) :
                      (bit_cnt + 4'h1 == srg_pkg::BITS_MODE23);
    // Modes 2/3 with address-only set deliver only when ninth bit is one
    assign deliver = !serial_control[srg_pkg::CTL_RX_DONE] &&
                     !(mode[1] && serial_control[srg_pkg::CTL_ADDR_ONLY] && !majority);

    srg_rate_gen u_rate (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .mode_i(mode),
        .ext_sel_i(ext_sel),
        .ext_count_input_i(ext_count_input_i),
        .rate_reload_value_i(rate_reload_value),
        .restart_i(restart),
        .bit_pulse_o(bit_pulse),
        .tick_o(tick)
    );

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_prev <= 1'b1;
            rx_en_prev <= 1'b0;
        end else if (ce_i) begin
            line_prev <= rx_line_i;
            rx_en_prev <= serial_control[srg_pkg::CTL_RX_EN];
        end
    end

    // Receive state machine; stop bit is never examined, so a bad stop is silent
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= SRG_IDLE;
            tick_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            votes <= 2'h0;
            shifter <= 9'h000;
        end else if (ce_i) begin
            if (!serial_control[srg_pkg::CTL_RX_EN] || restart) begin
                state <= SRG_IDLE;
                bit_cnt <= 4'h0;
            end else if (mode == srg_pkg::MODE_SHIFT) begin
                state <= SRG_IDLE;
                if (bit_pulse && !serial_control[srg_pkg::CTL_RX_DONE]) begin
                    shifter <= {rx_line_i, shifter[8:1]};
                    bit_cnt <= (bit_cnt == srg_pkg::BITS_SHIFT - 4'h1) ? 4'h0 : bit_cnt + 4'h1;
                end
            end else begin
                if (tick) begin
                    tick_cnt <= tick_cnt + 4'h1;
                    if (tick_cnt == srg_pkg::TICK_S7) votes[0] <= rx_line_i;
                    if (tick_cnt == srg_pkg::TICK_S8) votes[1] <= rx_line_i;
                end
                unique case (state)
                    SRG_IDLE: begin
                        if (line_prev && !rx_line_i) begin
                            state <= SRG_START;
                            tick_cnt <= 4'h0;
                            bit_cnt <= 4'h0;
                        end
                    end
                    SRG_START: begin
                        if (sample_now) begin
                            state <= majority ? SRG_IDLE : SRG_DATA;
                            bit_cnt <= 4'h1;
                        end
                    end
                    SRG_DATA: begin
                        if (sample_now) begin
                            shifter <= {majority, shifter[8:1]};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (last_bit) begin
                                state <= SRG_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Register file; receive-done set wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_control <= srg_pkg::CONTROL_RESET;
            serial_buffer <= 8'h00;
            rate_reload_value <= srg_pkg::RELOAD_RESET;
            ext_sel <= 1'b0;
        end else if (ce_i) begin
            if (wr && wb_adr_i == srg_pkg::ADDR_CONTROL) serial_control <= wb_dat_i[7:0];
            if (wr && wb_adr_i == srg_pkg::ADDR_RELOAD) rate_reload_value <= wb_dat_i[7:0];
            if (wr && wb_adr_i == srg_pkg::ADDR_RATE_CFG) ext_sel <= wb_dat_i[srg_pkg::CFG_EXT_SEL];
            if (tx_done_set_i) serial_control[srg_pkg::CTL_TX_DONE] <= 1'b1;
            if (serial_control[srg_pkg::CTL_RX_EN] && mode != srg_pkg::MODE_SHIFT &&
                state == SRG_DATA && sample_now && last_bit && deliver) begin
                serial_buffer <= mode[1] ? shifter[8:1] : {majority, shifter[8:2]};
                // Mode 1 carries no ninth bit, so the holder keeps its value there
                if (mode[1]) serial_control[srg_pkg::CTL_NINTH] <= majority;
                serial_control[srg_pkg::CTL_RX_DONE] <= 1'b1;
            end
            if (serial_control[srg_pkg::CTL_RX_EN] && !restart && mode == srg_pkg::MODE_SHIFT &&
                bit_pulse && !serial_control[srg_pkg::CTL_RX_DONE] &&
                bit_cnt == srg_pkg::BITS_SHIFT - 4'h1) begin
                serial_buffer <= {rx_line_i, shifter[8:2]};
                serial_control[srg_pkg::CTL_RX_DONE] <= 1'b1;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            srg_pkg::ADDR_CONTROL: next_rdata = {24'h00_0000, serial_control};
            srg_pkg::ADDR_BUFFER: next_rdata = {24'h00_0000, serial_buffer};
            srg_pkg::ADDR_RELOAD: next_rdata = {24'h00_0000, rate_reload_value};
            srg_pkg::ADDR_RATE_CFG: next_rdata = {31'h0000_0000, ext_sel};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // One wait-free answer; ack drops the cycle after it was given
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= rd_ack;
            wb_dat_o <= rd_ack ? next_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_irq_o <= 1'b0;
            shift_clk_o <= 1'b1;
        end else if (ce_i) begin
            serial_irq_o <= serial_control[srg_pkg::CTL_RX_DONE] |
                            serial_control[srg_pkg::CTL_TX_DONE];
            shift_clk_o <= !(mode == srg_pkg::MODE_SHIFT && bit_pulse);
        end
    end
endmodule

// File: verification/srg_serial_rx_checker.sv
`timescale 1ns/1ns
module srg_serial_rx_checker (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_done_set_i,
    input wire logic serial_irq_o,
    input wire logic shift_clk_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic req;
    logic ctl_wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    assign ctl_wr = req && wb_we_i && wb_adr_i == srg_pkg::ADDR_CONTROL;
    property p_ack_next; req |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_no_stray; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    a_no_stray: assert property (p_no_stray) else $error("ack without request");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_upper_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
    property p_irq_tx; tx_done_set_i && ce_i |-> ##2 serial_irq_o; endproperty
    a_irq_tx: assert property (p_irq_tx) else $error("irq missing after tx done");
    // Flags only drop when software writes control, so irq may only fall two edges later
    property p_irq_hold; $fell(serial_irq_o) |-> $past(ctl_wr, 2); endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq fell without clear");
    property p_shift_low; $fell(shift_clk_o) |=> shift_clk_o[*8]; endproperty
    a_shift_low: assert property (p_shift_low) else $error("shift clock low too long");
    c_ctl_wr: cover property (ctl_wr);
    c_irq: cover property ($rose(serial_irq_o));
    c_shift: cover property ($fell(shift_clk_o));
endmodule

// File: verification/srg_far_tx.sv
`timescale 1ns/1ns
module srg_far_tx (
    input wire logic core_clk_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // Start low, data LSB first, then stop; a low stop models a broken frame
    task automatic send(input logic [8:0] d, input int nb, input int bc, input logic stop);
        logic [10:0] fr;
        fr = {1'b1, d, 1'b0};
        fr[nb + 1] = stop;
        for (int i = 0; i < nb + 2; i++) begin
            line_o <= fr[i];
            repeat (bc) @(posedge core_clk_i);
        end
    endtask
    task automatic hold(input logic v, input int n);
        line_o <= v;
        repeat (n) @(posedge core_clk_i);
    endtask
endmodule

// File: verification/serial_rate_gen_rx_buffer_tb.sv
`timescale 1ns/1ns
module serial_rate_gen_rx_buffer_tb;
    localparam logic [3:0] a_ctl = srg_pkg::ADDR_CONTROL;
    localparam logic [3:0] a_buf = srg_pkg::ADDR_BUFFER;
    logic clk, rst_n, ce, cyc, stb, we, ack, line, ext, txs, irq, sclk, erun;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [1:0] ediv;
    int mismatches, n_checks, cycles, n;
    srg_serial_rx dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rx_line_i(line), .ext_count_input_i(ext),
        .tx_done_set_i(txs), .serial_irq_o(irq), .shift_clk_o(sclk));
    srg_far_tx far_u (.core_clk_i(clk), .line_o(line));
    assign ext = ediv[1];
    always @(posedge clk) ediv <= erun ? ediv + 2'h1 : 2'h0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00, 4'hf);
        chk(q, exp);
    endtask
    task automatic t_regs;
        rd(a_ctl, {24'h0, srg_pkg::CONTROL_RESET});
        rd(srg_pkg::ADDR_RELOAD, {24'h0, srg_pkg::RELOAD_RESET});
        bus(1'b1, srg_pkg::ADDR_RELOAD, 8'h5a, 4'h0);
        rd(srg_pkg::ADDR_RELOAD, 32'h0);
        wr(srg_pkg::ADDR_RELOAD, 8'h5a);
        rd(srg_pkg::ADDR_RELOAD, 32'h5a);
        wr(4'h1, 8'hff);
        rd(4'h1, 32'h0);
        txs <= 1'b1;
        @(posedge clk);
        txs <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(a_ctl, 32'h2);
        wr(a_ctl, 8'h00);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_mode2;
        wr(a_ctl, {srg_pkg::MODE_UART9_FIXED, 6'h10});
        far_u.send(9'h1a5, 9, 64, 1'b1);
        rd(a_buf, 32'ha5);
        rd(a_ctl, 32'h95);
        chk({31'h0, irq}, 32'h1);
        far_u.send(9'h03c, 9, 64, 1'b1);
        rd(a_buf, 32'ha5);
        rd(a_ctl, 32'h95);
        wr(a_ctl, 8'h90);
        far_u.send(9'h03c, 9, 64, 1'b1);
        rd(a_buf, 32'h3c);
        rd(a_ctl, 32'h91);
        wr(a_ctl, 8'hb0);
        far_u.send(9'h011, 9, 64, 1'b1);
        rd(a_ctl, 32'hb0);
        far_u.send(9'h122, 9, 64, 1'b1);
        rd(a_buf, 32'h22);
        rd(a_ctl, 32'hb5);
        $display("t_mode2 done");
    endtask
    task automatic t_stop;
        wr(a_ctl, 8'h90);
        far_u.send(9'h0f0, 9, 64, 1'b0);
        rd(a_buf, 32'hf0);
        rd(a_ctl, 32'h91);
        wr(a_ctl, 8'h90);
        far_u.hold(1'b0, 768);
        rd(a_ctl, 32'h90);
        far_u.hold(1'b1, 64);
        far_u.send(9'h055, 9, 64, 1'b1);
        rd(a_buf, 32'h55);
        $display("t_stop done");
    endtask
    task automatic t_rates;
        wr(srg_pkg::ADDR_RELOAD, 8'hfe);
        wr(srg_pkg::ADDR_RATE_CFG, 8'h01);
        erun <= 1'b1;
        // Re-enable so the counter restarts from the new reload value
        wr(a_ctl, 8'h00);
        wr(a_ctl, {srg_pkg::MODE_UART9_VAR, 6'h10});
        far_u.send(9'h0c3, 9, 256, 1'b1);
        rd(a_buf, 32'hc3);
        rd(a_ctl, 32'hd1);
        wr(srg_pkg::ADDR_RATE_CFG, 8'h00);
        erun <= 1'b0;
        wr(a_ctl, {srg_pkg::MODE_UART8, 6'h10});
        far_u.send(9'h0e9, 8, 768, 1'b1);
        rd(a_buf, 32'he9);
        rd(a_ctl, 32'h51);
        chk({31'h0, irq}, 32'h1);
        $display("t_rates done");
    endtask
    task automatic t_shift;
        wr(a_ctl, 8'h00);
        wr(a_ctl, {srg_pkg::MODE_SHIFT, 6'h10});
        repeat (200) if (sclk !== 1'b0) @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sclk !== 1'b0 && n < 100);
        chk(n, 32'd12);
        repeat (120) @(posedge clk);
        rd(a_buf, 32'hff);
        rd(a_ctl, 32'h11);
        $display("t_shift done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {rst_n, cyc, stb, we, txs, erun, ediv, adr, wdat} = '0;
        {ce, sel, mismatches, n_checks, cycles} = {1'b1, 4'hf, 96'h0};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_mode2();
        t_stop();
        t_rates();
        t_shift();
        wrap_up();
    end
endmodule
bind srg_serial_rx srg_serial_rx_checker chk_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_done_set_i(tx_done_set_i), .serial_irq_o(serial_irq_o), .shift_clk_o(shift_clk_o));
